// *** hw/map_entry.sv ***
/*
 * One mapping entry: translated bits, enable and target kind.
 * Assumes the owner decodes the write strobe for this entry.
 */
`timescale 1ns/1ps
`default_nettype none
`include "page_mapper_map.svh"

module map_entry
(
	input  wire logic       mclk_i,
	input  wire logic       resetn_i,
	input  wire logic       wr_low_i,
	input  wire logic       wr_high_i,
	input  wire logic [7:0] wdata_i,
	output logic      [7:0] low_o,
	output logic      [7:0] high_o
);
	logic [7:0] low;
	logic [7:0] high;

	// Entry storage; reserved high bits are kept zero
	always_ff @(posedge mclk_i or negedge resetn_i)
	begin
		if (!resetn_i)
		begin
			low  <= `PM_ENTRY_LOW_RESET;
			high <= `PM_ENTRY_HIGH_RESET;
		end
		else
		begin
			if (wr_low_i)
				low <= wdata_i;
			if (wr_high_i)
				high <= wdata_i & 8'hB3;
		end
	end

	assign low_o  = low;
	assign high_o = high;
endmodule // map_entry

`default_nettype wire

// *** hw/memory_page_mapper.sv ***
/*
 * Page mapper: I/O page select plus two data ports per entry, and the
 * translation of CPU memory addresses into device selects.
 * Assumes single-cycle I/O strobes and memory requests on mclk_i.
 */
// Functional notes
// - Bits 7:2 of the page select port choose the entry the data ports reach.
// - The low data port holds translated bits A21..A14 of the selected page.
// - The high data port holds A23..A22 in bits 1:0 with enable and kind.
// - High bit 7 enables translation of the page and resets to off.
// - High bits 5:4 pick none, RAM, ROM 0 or ROM 1, resetting to none.
// - Kind none sends accesses in the page to an expansion bus cycle.
// - Kind RAM selects RAM of the type given by the RAM type input.
`timescale 1ns/1ps
`default_nettype none
`include "page_mapper_map.svh"

module memory_page_mapper
#(
	parameter int ENTRIES = 64
)
(
	input  wire logic        mclk_i,
	input  wire logic        resetn_i,
	input  wire logic [7:0]  io_addr_i,
	input  wire logic [7:0]  io_wdata_i,
	input  wire logic        io_wr_i,
	input  wire logic        io_rd_i,
	output logic      [7:0]  io_rdata_o,
	input  wire logic        mem_req_i,
	input  wire logic [23:0] mem_addr_i,
	input  wire logic [3:0]  ram_type_i,
	output logic      [23:0] mem_addr_o,
	output logic             sel_exp_o,
	output logic             sel_ram_o,
	output logic      [3:0]  ram_type_o,
	output logic             sel_rom0_o,
	output logic             sel_rom1_o,
	output logic             mem_valid_o
);
	logic [7:0] page_sel;
	logic [7:0] low_arr  [ENTRIES];
	logic [7:0] high_arr [ENTRIES];
	logic [7:0] rdata;
	logic [23:0] maddr;
	logic        vld;
	logic        s_exp;
	logic        s_ram;
	logic        s_rom0;
	logic        s_rom1;
	logic [3:0]  rtype;

	wire logic [5:0] cur_page = page_sel[`PM_PAGE_SEL_MSB:`PM_PAGE_SEL_LSB];
	wire logic hit_sel  = (io_addr_i == `PM_OFS_PAGE_SEL);
	wire logic hit_low  = (io_addr_i == `PM_OFS_ENTRY_LOW);
	wire logic hit_high = (io_addr_i == `PM_OFS_ENTRY_HIGH);

	// Entries, each written only when the page select points at it
	genvar g;
	generate
		for (g = 0; g < ENTRIES; g++)
		begin : g_ent
			map_entry u_ent
			(
				.mclk_i    (mclk_i),
				.resetn_i  (resetn_i),
				.wr_low_i  (io_wr_i && hit_low && cur_page == 6'(g)),
				.wr_high_i (io_wr_i && hit_high && cur_page == 6'(g)),
				.wdata_i   (io_wdata_i),
				.low_o     (low_arr[g]),
				.high_o    (high_arr[g])
			);
		end
	endgenerate

	// Page select register; low two bits held at zero
	always_ff @(posedge mclk_i or negedge resetn_i)
	begin
		if (!resetn_i)
			page_sel <= `PM_PAGE_SEL_RESET;
		else if (io_wr_i && hit_sel)
			page_sel <= io_wdata_i & 8'hFC;
	end

	// Read data selection
	wire logic [7:0] next_rdata = hit_sel  ? page_sel :
		hit_low  ? low_arr[cur_page] :
		hit_high ? high_arr[cur_page] :
		8'h00;

	always_ff @(posedge mclk_i or negedge resetn_i)
	begin
		if (!resetn_i)
			rdata <= 8'h00;
		else if (io_rd_i)
			rdata <= next_rdata;
	end

	// Translation lookup of the incoming page
	wire logic [5:0] mpage = mem_addr_i[19:14];
	wire logic [7:0] m_low  = low_arr[mpage];
	wire logic [7:0] m_high = high_arr[mpage];
	wire logic m_en = m_high[`PM_HIGH_EN_BIT];
	wire page_mapper_pkg::target_device_kind_t m_kind =
		page_mapper_pkg::target_device_kind_t'(
		m_high[`PM_HIGH_KIND_MSB:`PM_HIGH_KIND_LSB]);
	wire logic [23:0] next_maddr = m_en ?
		{m_high[`PM_HIGH_ADDR_MSB:`PM_HIGH_ADDR_LSB], m_low,
		mem_addr_i[`PM_PAGE_BIT-1:0]} : mem_addr_i;
	wire logic next_exp  = !m_en || m_kind == page_mapper_pkg::KIND_NONE;
	wire logic next_ram  = m_en && m_kind == page_mapper_pkg::KIND_RAM;
	wire logic next_rom0 = m_en && m_kind == page_mapper_pkg::KIND_ROM0;
	wire logic next_rom1 = m_en && m_kind == page_mapper_pkg::KIND_ROM1;

	// Registered steering of each memory request
	always_ff @(posedge mclk_i or negedge resetn_i)
	begin
		if (!resetn_i)
		begin
			maddr  <= 24'h000000;
			vld    <= 1'b0;
			s_exp  <= 1'b0;
			s_ram  <= 1'b0;
			s_rom0 <= 1'b0;
			s_rom1 <= 1'b0;
			rtype  <= 4'h0;
		end
		else
		begin
			vld    <= mem_req_i;
			s_exp  <= mem_req_i && next_exp;
			s_ram  <= mem_req_i && next_ram;
			s_rom0 <= mem_req_i && next_rom0;
			s_rom1 <= mem_req_i && next_rom1;
			if (mem_req_i)
			begin
				maddr <= next_maddr;
				rtype <= ram_type_i;
			end
		end
	end

	assign io_rdata_o  = rdata;
	assign mem_addr_o  = maddr;
	assign mem_valid_o = vld;
	assign sel_exp_o   = s_exp;
	assign sel_ram_o   = s_ram;
	assign sel_rom0_o  = s_rom0;
	assign sel_rom1_o  = s_rom1;
	assign ram_type_o  = rtype;

	// Page select low bits stay zero
	chk_sel_low_zero: assert property (
		@(posedge mclk_i) disable iff (!resetn_i)
		page_sel[1:0] == 2'b00)
		else $error("page select low bits set");

	// Steps of a high port write and its later read
	sequence seq_high_write;
		io_wr_i && hit_high;
	endsequence

	sequence seq_high_read;
		io_rd_i && hit_high && !io_wr_i;
	endsequence

	// Write to high port, a quiet cycle, then read back masked value
	chk_high_readback: assert property (
		@(posedge mclk_i) disable iff (!resetn_i)
		seq_high_write ##1 !io_wr_i ##1 seq_high_read
		|=> io_rdata_o == ($past(io_wdata_i, 3) & 8'hB3))
		else $error("high port readback mismatch");

	// Exactly one select with each valid
	chk_one_select: assert property (
		@(posedge mclk_i) disable iff (!resetn_i)
		mem_valid_o |-> $onehot({s_exp, s_ram, s_rom0, s_rom1}))
		else $error("select not one-hot");

	// Disabled page passes address to expansion bus
	chk_off_passthru: assert property (
		@(posedge mclk_i) disable iff (!resetn_i)
		(mem_req_i && !m_en) |=>
		(sel_exp_o && mem_addr_o == $past(mem_addr_i)))
		else $error("disabled page not passed through");

	// Enabled page gets translated upper bits
	chk_translate: assert property (
		@(posedge mclk_i) disable iff (!resetn_i)
		(mem_req_i && m_en) |=> mem_addr_o[23:14] ==
		$past({m_high[1:0], m_low}))
		else $error("bad translation");

	// RAM select carries RAM type
	chk_ram_type: assert property (
		@(posedge mclk_i) disable iff (!resetn_i)
		(mem_req_i && next_ram) |=>
		(sel_ram_o && ram_type_o == $past(ram_type_i)))
		else $error("RAM select or type wrong");

	// Selects idle without request
	chk_idle_quiet: assert property (
		@(posedge mclk_i) disable iff (!resetn_i)
		!mem_req_i |=>
		!(sel_exp_o || sel_ram_o || sel_rom0_o || sel_rom1_o))
		else $error("select without request");

	// Low port reads the selected entry
	chk_low_read: assert property (
		@(posedge mclk_i) disable iff (!resetn_i)
		(io_rd_i && hit_low) |=> io_rdata_o == $past(low_arr[cur_page]))
		else $error("low port read wrong entry");
endmodule // memory_page_mapper

`default_nettype wire

// *** include/page_mapper_map.svh ***
/*
 * Register offsets, field positions and reset values of the page mapper.
 * Assumes an 8-bit I/O port space decoded on the low address byte.
 */
`ifndef PAGE_MAPPER_MAP_SVH
`define PAGE_MAPPER_MAP_SVH

`define PM_OFS_PAGE_SEL     8'h6C
`define PM_OFS_ENTRY_LOW    8'h6E
`define PM_OFS_ENTRY_HIGH   8'h6F
`define PM_PAGE_SEL_MSB     7
`define PM_PAGE_SEL_LSB     2
`define PM_HIGH_EN_BIT      7
`define PM_HIGH_KIND_MSB    5
`define PM_HIGH_KIND_LSB    4
`define PM_HIGH_ADDR_MSB    1
`define PM_HIGH_ADDR_LSB    0
`define PM_PAGE_SEL_RESET   8'h00
`define PM_ENTRY_LOW_RESET  8'h00
`define PM_ENTRY_HIGH_RESET 8'h00
`define PM_PAGE_BIT         14

`endif

// *** include/page_mapper_pkg.sv ***
/*
 * Types shared by the page mapper files.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
`default_nettype none
package page_mapper_pkg;
	typedef enum logic [1:0] {
		KIND_NONE = 2'b00,
		KIND_RAM  = 2'b01,
		KIND_ROM0 = 2'b10,
		KIND_ROM1 = 2'b11
	} target_device_kind_t;
endpackage

`default_nettype wire

// *** verif/cpu_bus_model.sv ***
/*
 * CPU side model: I/O port cycles and memory requests.
 * Assumes the mapper samples its inputs on the rising edge of mclk_i.
 */
`timescale 1ns/1ps
`default_nettype none
module cpu_bus_model
(
	input  wire logic        mclk_i,
	output logic      [7:0]  io_addr_o,
	output logic      [7:0]  io_wdata_o,
	output logic             io_wr_o,
	output logic             io_rd_o,
	output logic             mem_req_o,
	output logic      [23:0] mem_addr_o
);
	// Idle bus at time zero
	initial
	begin
		{io_addr_o, io_wdata_o, io_wr_o, io_rd_o} = 18'h0;
		{mem_req_o, mem_addr_o} = 25'h0;
	end
	// One port cycle; released address and data lines show the inverse of the last value
	task automatic io_cycle(input logic wr, input logic [7:0] a, d);
		@(negedge mclk_i);
		io_addr_o = a;
		io_wdata_o = (a == 8'h6C) ? (d & 8'hFC) :
			(a == 8'h6F) ? (d & 8'hB3) : d;
		io_wr_o = wr;
		io_rd_o = !wr;
		@(negedge mclk_i);
		{io_wr_o, io_rd_o} = 2'h0;
		io_addr_o = ~a;
		io_wdata_o = ~io_wdata_o;
	endtask
	// One memory request pulse
	task automatic mem_cycle(input logic [23:0] a);
		@(negedge mclk_i);
		mem_addr_o = a;
		mem_req_o = 1'b1;
		@(negedge mclk_i);
		mem_req_o = 1'b0;
		mem_addr_o = ~a;
	endtask
endmodule // cpu_bus_model
`default_nettype wire

// *** verif/memory_page_mapper_tb_top.sv ***
/*
 * Self-checking bench for the page mapper.
 * Assumes cpu_bus_model drives the port and memory sides.
 */
`timescale 1ns/1ps
`default_nettype none
module memory_page_mapper_tb_top;
	logic        mclk_i = 1'b0;
	logic        resetn_i = 1'b0;
	logic [3:0]  ram_type_i = 4'h9;
	wire  [7:0]  a, d, q;
	wire         wr, rd, req, vld, s_e, s_r, s_0, s_1;
	wire  [23:0] ma, mo;
	wire  [3:0]  rt;
	int          n_errors = 0;
	int          checks = 0;
	int          cycles = 0;
	always #50 mclk_i = ~mclk_i;
	cpu_bus_model cpu (.mclk_i(mclk_i), .io_addr_o(a), .io_wdata_o(d),
		.io_wr_o(wr), .io_rd_o(rd), .mem_req_o(req), .mem_addr_o(ma));
	memory_page_mapper uut (.mclk_i(mclk_i), .resetn_i(resetn_i),
		.io_addr_i(a), .io_wdata_i(d), .io_wr_i(wr), .io_rd_i(rd),
		.io_rdata_o(q), .mem_req_i(req), .mem_addr_i(ma),
		.ram_type_i(ram_type_i), .mem_addr_o(mo), .sel_exp_o(s_e),
		.sel_ram_o(s_r), .ram_type_o(rt), .sel_rom0_o(s_0),
		.sel_rom1_o(s_1), .mem_valid_o(vld));
	// Compare one value
	task automatic check(input string n, input logic [23:0] e, g);
		checks++;
		if (g !== e)
		begin
			n_errors++;
			$display("MISMATCH %s expected %h seen %h", n, e, g);
		end
	endtask
	task automatic rd_chk(input logic [7:0] ad, e);
		cpu.io_cycle(1'b0, ad, 8'h00);
		@(negedge mclk_i);
		check("io_rdata_o", {16'h0, e}, {16'h0, q});
	endtask
	// Memory request, then wait for the valid pulse
	task automatic mem_chk(input logic [23:0] ad, ea, input logic [3:0] es);
		cpu.mem_cycle(ad);
		repeat (4)
		begin
			if (vld === 1'b1)
				break;
			@(negedge mclk_i);
		end
		check("selects", {19'h0, es, 1'b1},
			{19'h0, s_e, s_r, s_0, s_1, vld});
		check("mem_addr_o", ea, mo);
	endtask
	task automatic t_reset;
		rd_chk(8'h6C, 8'h00);
		rd_chk(8'h6E, 8'h00);
		rd_chk(8'h6F, 8'h00);
		$display("test reset done");
	endtask
	task automatic t_regs;
		cpu.io_cycle(1'b1, 8'h6C, 8'h08);
		cpu.io_cycle(1'b1, 8'h6E, 8'hA5);
		cpu.io_cycle(1'b1, 8'h6F, 8'hB1);
		rd_chk(8'h6F, 8'hB1);
		rd_chk(8'h6E, 8'hA5);
		cpu.io_cycle(1'b1, 8'h6C, 8'h0C);
		rd_chk(8'h6E, 8'h00);
		cpu.io_cycle(1'b1, 8'h6C, 8'h08);
		rd_chk(8'h6E, 8'hA5);
		$display("test registers done");
	endtask
	task automatic t_route;
		for (int k = 0; k < 4; k++)
		begin
			ram_type_i = 4'h5 + 4'(k); // Fresh type each pass
			cpu.io_cycle(1'b1, 8'h6F, 8'h82 | 8'(k << 4));
			mem_chk(24'hF09ABC, {2'h2, 8'hA5, 14'h1ABC}, 4'h8 >> k);
			if (k == 1)
				check("ram_type_o", {20'h0, 4'h6}, {20'h0, rt});
		end
		cpu.io_cycle(1'b1, 8'h6F, 8'h32);
		mem_chk(24'hF09ABC, 24'hF09ABC, 4'h8);
		$display("test routing done");
	endtask
	task automatic stop_test;
		$display("checks %0d n_errors %0d", checks, n_errors);
		if (n_errors == 0 && checks > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	// Cut a hang short
	always @(posedge mclk_i)
	begin
		cycles++;
		if (cycles == 3000)
		begin
			n_errors++;
			stop_test();
		end
	end
	initial
	begin
		repeat (16) @(negedge mclk_i);
		resetn_i = 1'b1;
		t_reset();
		t_regs();
		t_route();
		stop_test();
	end
endmodule // memory_page_mapper_tb_top
`default_nettype wire
